// *** src/ccu_top.sv ***
// capture/compare unit with AHB-Lite register slave
`timescale 1ns/1ns
`default_nettype none
module ccu_top
    import ccu_pkg::*;
#(
    parameter int TB_WIDTH = 16
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        pin_a_in,
    input  wire logic        pin_b_in,
    output logic             pin_a_out,
    output logic             pin_a_oe,
    output logic             pin_b_out,
    output logic             pin_b_oe,
    input  wire logic        timebase_tick,
    input  wire logic        tick_is_external,
    input  wire logic        sleep_req,
    input  wire logic        converter_enabled,
    output logic             conversion_start,
    output logic             unit_event_flag
);
    // the value pair is two bytes, so only a 16-bit timebase is served
    if (TB_WIDTH != 16) begin : g_width_chk
        $error("ccu_top: timebase must be 16 bits");
    end

    logic [7:0]          unit_control_r;
    logic [7:0]          value_low_byte_r;
    logic [7:0]          value_high_byte_r;
    logic                alternate_pin_select_r;
    logic [7:0]          pwm_period_value_r;
    logic [TB_WIDTH-1:0] tb_r;
    logic                ovf_r;
    logic                event_r;
    logic                cmp_latch_r;
    logic                reset_pending_r;
    logic                matched_r;
    logic [3:0]          pre_cnt_r;
    logic [CCU_PWM_BITS-1:0] pwm_cnt_r;
    logic [CCU_PWM_BITS-1:0] duty_act_r;
    logic                pwm_out_r;
    logic                wr_pend_r;
    logic [31:0]         addr_r;
    logic [31:0]         rdata_r;

    logic [3:0]          mode;
    logic                is_capture;
    logic                is_compare;
    logic                is_pwm;
    logic                owns_pin;
    logic                pin_drive;
    logic                match;
    logic                cap_edge;
    logic                cap_fire;
    logic                tick;
    logic                addr_ok;
    logic                wr_ctl;
    logic                clr_event;
    logic [TB_WIDTH-1:0] value_pair;
    logic                spec_reset;
    ccu_pin_if           pin_bus();

    // the pin routed by the alternate selection feeds the capture logic
    ccu_pin_sync u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin_in  (alternate_pin_select_r ? pin_b_in : pin_a_in),
        .pin     (pin_bus.src)
    );

    assign mode       = unit_control_r[CCU_MODE_MSB:CCU_MODE_LSB];
    assign value_pair = {value_high_byte_r, value_low_byte_r};
    assign is_capture = (mode >= CCU_M_CAP_FALL) && (mode <= CCU_M_CAP_R16);
    assign is_compare = (mode == CCU_M_CMP_TGL) || ((mode >= CCU_M_CMP_SET)
                        && (mode <= CCU_M_CMP_SPEC));
    assign is_pwm     = (mode >= CCU_M_PWM);
    // external ticks keep running in sleep, internal ones stop
    assign tick       = timebase_tick && (tick_is_external || !sleep_req);
    assign match      = is_compare && (tb_r == value_pair) && !sleep_req;
    // a tick in the very cycle of the first match is already the next edge
    assign spec_reset = tick && match && (reset_pending_r
                        || (!matched_r && mode == CCU_M_CMP_SPEC));

    // ---- AHB-Lite slave: zero wait states, always OKAY
    assign addr_ok   = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_r;
    assign wr_ctl    = wr_pend_r && (addr_r == CCU_OFF_CONTROL);
    assign clr_event = wr_pend_r && (addr_r == CCU_OFF_STATUS) && hwdata[CCU_ST_EVENT];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            addr_r    <= '0;
        end else begin
            wr_pend_r <= addr_ok && hwrite;
            addr_r    <= addr_ok ? {haddr[31:2], 2'b00} : addr_r;
        end
    end

    // read data registered in the address phase; unmapped reads as zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_r <= '0;
        end else if (addr_ok && !hwrite) begin
            unique case ({haddr[31:2], 2'b00})
                CCU_OFF_CONTROL:  rdata_r <= {24'h000000, unit_control_r};
                CCU_OFF_VALUE_LO: rdata_r <= {24'h000000, value_low_byte_r};
                CCU_OFF_VALUE_HI: rdata_r <= {24'h000000, value_high_byte_r};
                CCU_OFF_STATUS:   rdata_r <= {29'h0, sleep_req, ovf_r, event_r};
                CCU_OFF_TIMEBASE: rdata_r <= {16'h0000, tb_r};
                CCU_OFF_PINSEL:   rdata_r <= {31'h0, alternate_pin_select_r};
                CCU_OFF_PWM:      rdata_r <= {24'h000000, pwm_period_value_r};
                default:          rdata_r <= '0;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            unit_control_r         <= '0;
            value_low_byte_r       <= '0;
            value_high_byte_r      <= '0;
            alternate_pin_select_r <= 1'b0;
            pwm_period_value_r     <= '0;
        end else if (wr_pend_r) begin
            unique case (addr_r)
                CCU_OFF_CONTROL:  unit_control_r         <= hwdata[7:0];
                CCU_OFF_VALUE_LO: value_low_byte_r       <= hwdata[7:0];
                CCU_OFF_VALUE_HI: value_high_byte_r      <= hwdata[7:0];
                CCU_OFF_PINSEL:   alternate_pin_select_r <= hwdata[0];
                CCU_OFF_PWM:      pwm_period_value_r     <= hwdata[7:0];
                default:          ;
            endcase
        // a bus write to any register wins over a capture in the same cycle
        end else if (cap_fire) begin
            // newer capture overwrites an unread one
            {value_high_byte_r, value_low_byte_r} <= tb_r;
        end
    end

    // ---- timebase: shared counter model advanced by ticks
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tb_r  <= '0;
            ovf_r <= 1'b0;
        end else begin
            // a bus write to the timebase swallows a tick of the same cycle
            if (wr_pend_r && addr_r == CCU_OFF_TIMEBASE) begin
                tb_r <= hwdata[TB_WIDTH-1:0];
            end else if (tick) begin
                // pending reset is dropped if the match went away
                if (spec_reset) begin
                    tb_r <= '0;
                end else begin
                    tb_r <= tb_r + 1'b1;
                end
            end
            if (tick && !spec_reset && (&tb_r)) begin
                ovf_r <= 1'b1;
            end else if (wr_pend_r && addr_r == CCU_OFF_STATUS && hwdata[CCU_ST_OVF]) begin
                ovf_r <= 1'b0;
            end
        end
    end

    // ---- compare: act once when the timebase first reaches the value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            matched_r       <= 1'b0;
            reset_pending_r <= 1'b0;
            cmp_latch_r     <= 1'b0;
        end else begin
            // sleep must not re-arm a match that still stands on wake
            matched_r <= sleep_req ? matched_r : match;
            if (match && !matched_r && mode == CCU_M_CMP_SPEC) begin
                reset_pending_r <= 1'b1;
            end else if (tick || !match) begin
                reset_pending_r <= 1'b0;
            end
            if (wr_ctl && hwdata[7:0] == 8'h00) begin
                cmp_latch_r <= 1'b0;
            end else if (match && !matched_r) begin
                unique case (mode)
                    CCU_M_CMP_TGL: cmp_latch_r <= !cmp_latch_r;
                    CCU_M_CMP_SET: cmp_latch_r <= 1'b1;
                    CCU_M_CMP_CLR: cmp_latch_r <= 1'b0;
                    default:       ;
                endcase
            end
        end
    end

    // trigger is immediate on the first matching cycle
    assign conversion_start = match && !matched_r && (mode == CCU_M_CMP_SPEC)
                              && converter_enabled;

    // ---- capture prescaler
    assign cap_edge = (mode == CCU_M_CAP_FALL) ? pin_bus.fall : pin_bus.rise;
    always_comb begin
        unique case (mode)
            CCU_M_CAP_R4:  cap_fire = cap_edge && (pre_cnt_r[1:0] == CCU_PRE_4[1:0]);
            CCU_M_CAP_R16: cap_fire = cap_edge && (pre_cnt_r == CCU_PRE_16);
            default:       cap_fire = cap_edge && is_capture;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_cnt_r <= '0;
        end else if (!is_capture) begin
            pre_cnt_r <= '0;
        end else if (cap_edge) begin
            // selection changes alone leave the count alone
            pre_cnt_r <= pre_cnt_r + 1'b1;
        end
    end

    // ---- event flag: set wins over software clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            event_r <= 1'b0;
        end else if (cap_fire || (match && !matched_r)) begin
            event_r <= 1'b1;
        end else if (clr_event) begin
            event_r <= 1'b0;
        end
    end
    assign unit_event_flag = event_r;

    // ---- standard PWM: 10-bit base from period value, duty from low value byte and control bits 5:4
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwm_cnt_r  <= '0;
            duty_act_r <= '0;
            pwm_out_r  <= 1'b0;
        end else if (!is_pwm) begin
            pwm_cnt_r <= '0;
            pwm_out_r <= 1'b0;
        end else if (pwm_cnt_r == {pwm_period_value_r, 2'b11}) begin
            pwm_cnt_r  <= '0;
            duty_act_r <= {value_low_byte_r, unit_control_r[5:4]};
            pwm_out_r  <= ({value_low_byte_r, unit_control_r[5:4]} != '0);
        end else begin
            pwm_cnt_r <= pwm_cnt_r + 1'b1;
            // a duty above the period never matches and keeps the pin high
            if (pwm_cnt_r + 1'b1 == duty_act_r) begin
                pwm_out_r <= 1'b0;
            end
        end
    end

    // ---- pin ownership: none when off, capture, flag-only or trigger modes
    assign owns_pin  = is_pwm || (is_compare && mode != CCU_M_CMP_IRQ
                       && mode != CCU_M_CMP_SPEC);
    assign pin_drive = is_pwm ? pwm_out_r : cmp_latch_r;
    // direction bit lives in the port; oe here only claims the pin
    assign pin_a_out = !alternate_pin_select_r && owns_pin && pin_drive;
    assign pin_a_oe  = !alternate_pin_select_r && owns_pin;
    assign pin_b_out = alternate_pin_select_r && owns_pin && pin_drive;
    assign pin_b_oe  = alternate_pin_select_r && owns_pin;
endmodule
`default_nettype wire

// *** src/ccu_pkg.sv ***
// capture/compare unit package: register map, mode codes, pin constants
package ccu_pkg;
    localparam logic [31:0] CCU_OFF_CONTROL   = 32'h0000_0000;
    localparam logic [31:0] CCU_OFF_VALUE_LO  = 32'h0000_0004;
    localparam logic [31:0] CCU_OFF_VALUE_HI  = 32'h0000_0008;
    localparam logic [31:0] CCU_OFF_STATUS    = 32'h0000_000C;
    localparam logic [31:0] CCU_OFF_TIMEBASE  = 32'h0000_0010;
    localparam logic [31:0] CCU_OFF_PINSEL    = 32'h0000_0014;
    localparam logic [31:0] CCU_OFF_PWM       = 32'h0000_0018;

    localparam int CCU_MODE_LSB = 0;
    localparam int CCU_MODE_MSB = 3;

    // unit_mode_field codes
    localparam logic [3:0] CCU_M_OFF      = 4'h0;
    localparam logic [3:0] CCU_M_CMP_TGL  = 4'h2;
    localparam logic [3:0] CCU_M_CAP_FALL = 4'h4;
    localparam logic [3:0] CCU_M_CAP_RISE = 4'h5;
    localparam logic [3:0] CCU_M_CAP_R4   = 4'h6;
    localparam logic [3:0] CCU_M_CAP_R16  = 4'h7;
    localparam logic [3:0] CCU_M_CMP_SET  = 4'h8;
    localparam logic [3:0] CCU_M_CMP_CLR  = 4'h9;
    localparam logic [3:0] CCU_M_CMP_IRQ  = 4'hA;
    localparam logic [3:0] CCU_M_CMP_SPEC = 4'hB;
    localparam logic [3:0] CCU_M_PWM      = 4'hC;

    localparam logic [3:0] CCU_PRE_4  = 4'h3;
    localparam logic [3:0] CCU_PRE_16 = 4'hF;

    localparam int CCU_PWM_BITS = 10;
    localparam int CCU_SYNC_STAGES = 3;

    // status bits
    localparam int CCU_ST_EVENT = 0;
    localparam int CCU_ST_OVF   = 1;
    localparam int CCU_ST_SLEEP = 2;
endpackage

// *** src/ccu_pin_if.sv ***
// carrier between the core and its pin synchroniser
`timescale 1ns/1ns
`default_nettype none
interface ccu_pin_if;
    logic level;
    logic rise;
    logic fall;
    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface
`default_nettype wire

// *** src/ccu_pin_sync.sv ***
// three-stage synchroniser and edge detector for the unit pin input
`timescale 1ns/1ns
`default_nettype none
module ccu_pin_sync
    import ccu_pkg::*;
(
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic pin_in,
    ccu_pin_if.src    pin
);
    logic [CCU_SYNC_STAGES-1:0] sync_r;
    logic                       level_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_r <= '0;
        end else begin
            sync_r <= {sync_r[CCU_SYNC_STAGES-2:0], pin_in};
        end
    end

    // a change counts only when the second and third stages agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level_r <= 1'b0;
        end else if (sync_r[1] == sync_r[2]) begin
            level_r <= sync_r[2];
        end
    end

    assign pin.level = level_r;
    assign pin.rise  = (sync_r[1] == sync_r[2]) && sync_r[2] && !level_r;
    assign pin.fall  = (sync_r[1] == sync_r[2]) && !sync_r[2] && level_r;
endmodule
`default_nettype wire

// *** testbench/ccu_props.sv ***
// assertion checker on the capture/compare unit ports
`timescale 1ns/1ns
`default_nettype none
module ccu_props
    import ccu_pkg::*;
#(
    parameter int TB_WIDTH = 16
) (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        pin_a_oe,
    input wire logic        pin_b_oe,
    input wire logic        sleep_req,
    input wire logic        converter_enabled,
    input wire logic        conversion_start,
    input wire logic        unit_event_flag
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    trig_needs_adc_a: assert property (conversion_start |-> converter_enabled)
        else $error("trigger without converter");
    trig_no_pin_a: assert property (conversion_start |-> !pin_a_oe && !pin_b_oe)
        else $error("trigger mode drives a pin");
    trig_flag_a: assert property (conversion_start |=> unit_event_flag)
        else $error("trigger without event flag");
    trig_once_a: assert property (conversion_start |=> !conversion_start)
        else $error("trigger longer than one cycle");
    sleep_quiet_a: assert property (sleep_req |-> !conversion_start)
        else $error("trigger while asleep");
    pin_excl_a: assert property (!(pin_a_oe && pin_b_oe))
        else $error("both pins driven");
    reset_idle_a: assert property ($rose(hresetn) |-> !pin_a_oe && !pin_b_oe && !unit_event_flag)
        else $error("outputs busy after reset");
    // only a status write may drop the flag
    flag_sw_clear_a: assert property ($fell(unit_event_flag) |-> $past(hwdata[0]) &&
        $past(hsel && htrans[1] && hwrite && haddr == CCU_OFF_STATUS, 2))
        else $error("event flag dropped without clear");

    cover property (conversion_start);
    cover property ($rose(unit_event_flag) && pin_b_oe);
    cover property ($fell(unit_event_flag));
endmodule
`default_nettype wire

// *** testbench/ccu_far_side.sv ***
// far side model: timebase tick source paced in system clocks
`timescale 1ns/1ns
`default_nettype none
module ccu_far_side (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic [7:0] tick_div,
    output logic            timebase_tick
);
    logic [7:0] cnt_r;

    // synchronous one-cycle tick, never at system clock rate; zero stops it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= 8'h00;
            timebase_tick <= 1'b0;
        end else begin
            cnt_r <= (cnt_r >= tick_div) ? 8'h00 : cnt_r + 8'h01;
            timebase_tick <= (tick_div > 8'h01) && (cnt_r == tick_div);
        end
    end
endmodule
`default_nettype wire

// *** testbench/capture_compare_unit_tb.sv ***
// self-checking bench for the capture/compare unit
`timescale 1ns/1ns
`default_nettype none
module capture_compare_unit_tb
    import ccu_pkg::*;
;
    logic        hclk, hresetn, hsel, hwrite, pin_a_in, pin_b_in, tick_is_external;
    logic        sleep_req, converter_enabled, hreadyout, hresp, pin_a_out, pin_a_oe;
    logic        pin_b_out, pin_b_oe, timebase_tick, conversion_start, unit_event_flag, sel;
    logic [31:0] haddr, hwdata, hrdata, rd, lfsr_r;
    logic [1:0]  htrans;
    logic [7:0]  tick_div, lo_b;
    int          failures, check_count, cnt;
    logic [3:0]  cmp_mode [4] = '{CCU_M_CMP_SET, CCU_M_CMP_CLR, CCU_M_CMP_TGL, CCU_M_CMP_IRQ};
    logic [3:0]  cap_mode [4] = '{CCU_M_CAP_FALL, CCU_M_CAP_RISE, CCU_M_CAP_R4, CCU_M_CAP_R16};
    int          cap_n [4] = '{1, 1, 4, 16};

    ccu_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pin_a_in, .pin_b_in, .pin_a_out,
        .pin_a_oe, .pin_b_out, .pin_b_oe, .timebase_tick, .tick_is_external, .sleep_req,
        .converter_enabled, .conversion_start, .unit_event_flag);
    ccu_far_side far_u (.hclk, .hresetn, .tick_div, .timebase_tick);

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one single transfer; entered just after a rising edge
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= a;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wait_for(ref logic s);
        for (int n = 0; n < 600 && s !== 1'b1; n++) @(posedge hclk);
        chk(s, 1'b1);
    endtask

    task automatic pulse();
        pin_a_in <= 1'b1;
        repeat (6) @(posedge hclk);
        pin_a_in <= 1'b0;
        repeat (6) @(posedge hclk);
    endtask

    task automatic pair_chk(input logic [15:0] exp);
        xfer(1'b0, CCU_OFF_VALUE_LO, 32'h0);
        lo_b = rd[7:0];
        xfer(1'b0, CCU_OFF_VALUE_HI, 32'h0);
        chk({rd[7:0], lo_b}, 32'(exp));
    endtask

    task automatic results();
        if (failures == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        #3000000;
        failures++;
        results();
    end

    initial begin
        {hresetn, hsel, hwrite, pin_a_in, pin_b_in, tick_is_external} = '0;
        {sleep_req, converter_enabled, haddr, hwdata, htrans, tick_div} = '0;
        {failures, check_count} = '0;
        lfsr_r = 32'h620E;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(1'b1, 32'h0000_0040, 32'hFFFF_FFFF);
        for (int i = 0; i < 8; i++) begin
            xfer(1'b0, 32'(i * 4), 32'h0);
            chk(rd, 32'h0);
            chk({hreadyout, hresp}, 32'h2);
        end
        xfer(1'b0, 32'h0000_0040, 32'h0);
        chk(rd, 32'h0);
        tick_div <= 8'h14;
        foreach (cmp_mode[k]) begin
            lfsr_r = lfsr_next(lfsr_r);
            sel = lfsr_r[16];
            xfer(1'b1, CCU_OFF_CONTROL, 32'h0);
            #1 chk(pin_a_out | pin_b_out | pin_a_oe | pin_b_oe, 32'h0);
            xfer(1'b1, CCU_OFF_STATUS, 32'h3);
            xfer(1'b1, CCU_OFF_PINSEL, 32'(sel));
            xfer(1'b1, CCU_OFF_VALUE_LO, 32'(lfsr_r[7:0]));
            xfer(1'b1, CCU_OFF_VALUE_HI, 32'(lfsr_r[15:8]));
            xfer(1'b1, CCU_OFF_TIMEBASE, 32'(lfsr_r[15:0] - 16'h0002));
            xfer(1'b1, CCU_OFF_CONTROL, 32'(cmp_mode[k]));
            #1 chk(sel ? pin_b_out : pin_a_out, 1'b0);
            wait_for(unit_event_flag);
            #1 chk(sel ? pin_b_oe : pin_a_oe, cmp_mode[k] != CCU_M_CMP_IRQ);
            chk(sel ? pin_b_out : pin_a_out, cmp_mode[k] inside {CCU_M_CMP_SET, CCU_M_CMP_TGL});
            xfer(1'b1, CCU_OFF_STATUS, 32'h1);
            repeat (4) @(posedge hclk);
            #1 chk(unit_event_flag, 1'b0);
        end
        converter_enabled <= 1'b1;
        xfer(1'b1, CCU_OFF_CONTROL, 32'h0);
        xfer(1'b1, CCU_OFF_VALUE_HI, 32'h12);
        xfer(1'b1, CCU_OFF_VALUE_LO, 32'h34);
        for (int c = 0; c < 2; c++) begin
            xfer(1'b1, CCU_OFF_STATUS, 32'h3);
            xfer(1'b1, CCU_OFF_TIMEBASE, 32'h1232);
            xfer(1'b1, CCU_OFF_CONTROL, 32'(CCU_M_CMP_SPEC));
            wait_for(conversion_start);
            if (c == 1)
                xfer(1'b1, CCU_OFF_VALUE_LO, 32'h35);
            wait_for(timebase_tick);
            xfer(1'b0, CCU_OFF_TIMEBASE, 32'h0);
            chk(rd, (c == 1) ? 32'h1235 : 32'h0);
            xfer(1'b0, CCU_OFF_STATUS, 32'h0);
            chk(rd & 32'h2, 32'h0);
        end
        // capture: timebase frozen so captured values are exact
        converter_enabled <= 1'b0;
        tick_div <= 8'h00;
        xfer(1'b1, CCU_OFF_PINSEL, 32'h0);
        foreach (cap_mode[k]) begin
            xfer(1'b1, CCU_OFF_CONTROL, 32'h0);
            xfer(1'b1, CCU_OFF_CONTROL, 32'(cap_mode[k]));
            xfer(1'b1, CCU_OFF_STATUS, 32'h1);
            for (int j = 0; j < 2; j++) begin
                lfsr_r = lfsr_next(lfsr_r);
                xfer(1'b1, CCU_OFF_TIMEBASE, 32'(lfsr_r[15:0]));
                for (int e = 0; e < cap_n[k]; e++) begin
                    chk(unit_event_flag, j != 0);
                    pulse();
                end
                chk(unit_event_flag, 1'b1);
                pair_chk(lfsr_r[15:0]);
            end
        end
        sleep_req <= 1'b1;
        tick_div <= 8'h03;
        xfer(1'b1, CCU_OFF_TIMEBASE, 32'h0100);
        repeat (30) @(posedge hclk);
        xfer(1'b0, CCU_OFF_TIMEBASE, 32'h0);
        chk(rd, 32'h0100);
        tick_is_external <= 1'b1;
        xfer(1'b1, CCU_OFF_CONTROL, 32'h0);
        xfer(1'b1, CCU_OFF_CONTROL, 32'(CCU_M_CAP_RISE));
        xfer(1'b1, CCU_OFF_STATUS, 32'h1);
        repeat (30) @(posedge hclk);
        tick_div <= 8'h00;
        repeat (8) @(posedge hclk);
        xfer(1'b0, CCU_OFF_TIMEBASE, 32'h0);
        chk(rd[15:0] > 16'h0100, 1'b1);
        lfsr_r = rd;
        pulse();
        chk(unit_event_flag, 1'b1);
        pair_chk(lfsr_r[15:0]);
        sleep_req <= 1'b0;
        xfer(1'b1, CCU_OFF_CONTROL, 32'h0);
        xfer(1'b1, CCU_OFF_PWM, 32'h3);
        xfer(1'b1, CCU_OFF_VALUE_LO, 32'h2);
        xfer(1'b1, CCU_OFF_CONTROL, 32'(CCU_M_PWM));
        repeat (40) @(posedge hclk);
        cnt = 0;
        repeat (64) begin
            @(posedge hclk);
            cnt += int'(pin_a_out === 1'b1);
        end
        chk(32'(cnt), 32'd32);
        chk(pin_a_oe, 1'b1);
        results();
    end
endmodule

bind ccu_top ccu_props #(.TB_WIDTH(TB_WIDTH)) chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hwdata, .pin_a_oe, .pin_b_oe, .sleep_req, .converter_enabled, .conversion_start,
    .unit_event_flag);
`default_nettype wire
